// [pkg/lane_status_pkg.sv]
package lane_status_pkg;
  localparam logic [11:0] LANE6_STATUS_ADDR = 12'h4B6;
  localparam logic [11:0] LANE7_STATUS_ADDR = 12'h4B7;
  localparam logic [11:0] IRQ_ENABLE_A_ADDR = 12'h4B8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WMASK = 8'hF8;
  localparam int BIT_DISPARITY = 7;
  localparam int BIT_INVALID = 6;
  localparam int BIT_STRAY = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ALIGN = 3;
  localparam int BIT_CHECKSUM = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_CODEGROUP = 0;
endpackage

// [design/lane_status_gen.sv]
`timescale 1ns/1ps
module lane_status_gen
  import lane_status_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [CNT_W-1:0] error_threshold, // Error threshold
  input wire logic [CNT_W-1:0] disparity_count, // Bad disparity count
  input wire logic [CNT_W-1:0] invalid_count, // Not-in-table count
  input wire logic [CNT_W-1:0] stray_count, // Unexpected K count
  input wire logic deskew_ok, // Deskew achieved
  input wire logic align_sync, // Alignment sync achieved
  input wire logic [CNT_W-1:0] rx_checksum, // Checksum sent in alignment sequence
  input wire logic [CNT_W-1:0] calc_checksum, // Checksum computed locally
  input wire logic frame_sync, // Frame sync achieved
  input wire logic codegroup_sync, // Code group sync achieved
  output logic [7:0] status // Registered status byte
);
  typedef struct packed {
    logic [7:0] status_reg;
  } state_t;
  state_t st_reg;
  state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.status_reg[BIT_DISPARITY] = disparity_count >= error_threshold;
    st_next.status_reg[BIT_INVALID] = invalid_count >= error_threshold;
    st_next.status_reg[BIT_STRAY] = stray_count >= error_threshold;
    st_next.status_reg[BIT_DESKEW] = deskew_ok;
    st_next.status_reg[BIT_ALIGN] = align_sync;
    // Only link-delivered checksum is used, never a programmed one
    st_next.status_reg[BIT_CHECKSUM] = rx_checksum == calc_checksum;
    st_next.status_reg[BIT_FRAME] = frame_sync;
    st_next.status_reg[BIT_CODEGROUP] = codegroup_sync;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{status_reg: STATUS_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign status = st_reg.status_reg;

  a_disp_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    (disparity_count >= error_threshold) |=> status[BIT_DISPARITY]) else $error("disparity flag missing");
  a_invalid_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    (invalid_count < error_threshold) |=> !status[BIT_INVALID]) else $error("invalid flag wrong");
  a_stray_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    (stray_count >= error_threshold) |=> status[BIT_STRAY]) else $error("stray flag missing");
  a_deskew_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 status[BIT_DESKEW] == $past(deskew_ok)) else $error("deskew bit wrong");
  a_align_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 status[BIT_ALIGN] == $past(align_sync)) else $error("align bit wrong");
  a_cksum_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    (rx_checksum != calc_checksum) |=> !status[BIT_CHECKSUM]) else $error("checksum bit wrong");
  a_frame_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 status[BIT_FRAME] == $past(frame_sync)) else $error("frame bit wrong");
  a_cgs_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    codegroup_sync [*2] |-> status[BIT_CODEGROUP]) else $error("code group bit wrong");
endmodule

// [design/lane_link_status_bank.sv]
`timescale 1ns/1ps
module lane_link_status_bank
  import lane_status_pkg::*;
#(
  parameter int NUM_LANES = 2,
  parameter int CNT_W = 8
) (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [11:0] cfg_addr, // Register address
  input wire logic cfg_wr, // Write strobe
  input wire logic cfg_rd, // Read strobe
  input wire logic [7:0] cfg_wdata, // Write data
  output logic [7:0] cfg_rdata, // Read data, held until next read, cleared by reset
  input wire logic [CNT_W-1:0] error_threshold, // Error threshold
  input wire logic skip_alignment_sequence, // Alignment sequence skipped
  input wire logic [NUM_LANES*CNT_W-1:0] disparity_count, // Per lane counts
  input wire logic [NUM_LANES*CNT_W-1:0] invalid_count, // Per lane counts
  input wire logic [NUM_LANES*CNT_W-1:0] stray_count, // Per lane counts
  input wire logic [NUM_LANES-1:0] deskew_ok, // Per lane deskew
  input wire logic [NUM_LANES-1:0] align_sync, // Per lane alignment sync
  input wire logic [NUM_LANES*CNT_W-1:0] rx_checksum, // Transmitted checksums
  input wire logic [NUM_LANES*CNT_W-1:0] calc_checksum, // Computed checksums
  input wire logic [NUM_LANES-1:0] frame_sync, // Per lane frame sync
  input wire logic [NUM_LANES-1:0] codegroup_sync, // Per lane code group sync
  output logic irq_req // Interrupt request, level
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Register map only holds lanes 6 and 7, so two lanes exactly
  if (NUM_LANES != 2) begin : g_bad_lanes
    $error("NUM_LANES must be 2: lanes 6 and 7");
  end
  if (CNT_W < 1) begin : g_bad_width
    $error("CNT_W must be at least 1");
  end

  typedef struct packed {
    logic [7:0] enable_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;
  } state_t;
  state_t st_reg;
  state_t st_next;
  logic [7:0] lane_status [NUM_LANES];
  logic [7:0] events;

  // ----------------------------------------
  // Per lane status
  // ----------------------------------------
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    lane_status_gen #(.CNT_W(CNT_W)) u_lane (
      .mclk(mclk),
      .reset_n(reset_n),
      .error_threshold(error_threshold),
      .disparity_count(disparity_count[i*CNT_W +: CNT_W]),
      .invalid_count(invalid_count[i*CNT_W +: CNT_W]),
      .stray_count(stray_count[i*CNT_W +: CNT_W]),
      .deskew_ok(deskew_ok[i]),
      .align_sync(align_sync[i]),
      .rx_checksum(rx_checksum[i*CNT_W +: CNT_W]),
      .calc_checksum(calc_checksum[i*CNT_W +: CNT_W]),
      .frame_sync(frame_sync[i]),
      .codegroup_sync(codegroup_sync[i]),
      .status(lane_status[i])
    );
  end

  // ----------------------------------------
  // Register access and interrupt
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // Error flags and lost deskew or alignment sync across both lanes
    events = '0;
    for (int i = 0; i < NUM_LANES; i++) begin
      events[BIT_DISPARITY] = events[BIT_DISPARITY] | lane_status[i][BIT_DISPARITY];
      events[BIT_INVALID] = events[BIT_INVALID] | lane_status[i][BIT_INVALID];
      events[BIT_STRAY] = events[BIT_STRAY] | lane_status[i][BIT_STRAY];
      events[BIT_DESKEW] = events[BIT_DESKEW] | ~lane_status[i][BIT_DESKEW];
      events[BIT_ALIGN] = events[BIT_ALIGN] | ~lane_status[i][BIT_ALIGN];
    end
    // Alignment-based events mean nothing while the sequence is skipped
    if (skip_alignment_sequence) begin
      events[BIT_DESKEW] = 1'b0;
      events[BIT_ALIGN] = 1'b0;
    end
    st_next.irq_reg = |(events & st_reg.enable_reg);
    if (cfg_wr && cfg_addr == IRQ_ENABLE_A_ADDR) begin
      st_next.enable_reg = cfg_wdata & ENABLE_WMASK;
    end
    if (cfg_rd) begin
      unique case (cfg_addr)
        LANE6_STATUS_ADDR: st_next.rdata_reg = lane_status[0];
        LANE7_STATUS_ADDR: st_next.rdata_reg = lane_status[1];
        IRQ_ENABLE_A_ADDR: st_next.rdata_reg = st_reg.enable_reg;
        default: st_next.rdata_reg = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{enable_reg: ENABLE_RESET, rdata_reg: 8'h00, irq_reg: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rdata = st_reg.rdata_reg;
  assign irq_req = st_reg.irq_reg;

  a_enable_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_wr && cfg_addr == IRQ_ENABLE_A_ADDR) |=> st_reg.enable_reg == ($past(cfg_wdata) & ENABLE_WMASK))
    else $error("enable write lost");
  a_irq_masked: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.enable_reg == 8'h00) |=> !irq_req) else $error("irq without enable");
  a_status_ro: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_rd && cfg_addr == LANE7_STATUS_ADDR) |=> cfg_rdata == $past(lane_status[1]))
    else $error("status read wrong");

  // ----------------------------------------
  // Interrupt event sequences
  // ----------------------------------------
  sequence s_disp_armed;
    st_reg.enable_reg[BIT_DISPARITY] && (lane_status[0][BIT_DISPARITY] || lane_status[1][BIT_DISPARITY]);
  endsequence

  sequence s_invalid_armed;
    st_reg.enable_reg[BIT_INVALID] && (lane_status[0][BIT_INVALID] || lane_status[1][BIT_INVALID]);
  endsequence

  sequence s_stray_armed;
    st_reg.enable_reg[BIT_STRAY] && (lane_status[0][BIT_STRAY] || lane_status[1][BIT_STRAY]);
  endsequence

  // Lost alignment counts only while the sequence is really in use
  sequence s_deskew_armed;
    st_reg.enable_reg[BIT_DESKEW] && !skip_alignment_sequence
      && (!lane_status[0][BIT_DESKEW] || !lane_status[1][BIT_DESKEW]);
  endsequence

  sequence s_align_armed;
    st_reg.enable_reg[BIT_ALIGN] && !skip_alignment_sequence
      && (!lane_status[0][BIT_ALIGN] || !lane_status[1][BIT_ALIGN]);
  endsequence

  // Only alignment-based enables set while the sequence is skipped
  sequence s_skip_only;
    skip_alignment_sequence && ((st_reg.enable_reg & ~8'h18) == 8'h00);
  endsequence

  sequence s_read_unmapped;
    cfg_rd && cfg_addr != LANE6_STATUS_ADDR && cfg_addr != LANE7_STATUS_ADDR
      && cfg_addr != IRQ_ENABLE_A_ADDR;
  endsequence

  sequence s_read_enable;
    cfg_rd && cfg_addr == IRQ_ENABLE_A_ADDR;
  endsequence

  // ----------------------------------------
  // Interrupt checks
  // ----------------------------------------
  a_irq_disp: assert property (@(posedge mclk) disable iff (!reset_n)
    s_disp_armed |=> irq_req) else $error("disparity irq missing");

  a_irq_invalid: assert property (@(posedge mclk) disable iff (!reset_n)
    s_invalid_armed |=> irq_req) else $error("invalid code irq missing");

  a_irq_stray: assert property (@(posedge mclk) disable iff (!reset_n)
    s_stray_armed |=> irq_req) else $error("stray char irq missing");

  a_irq_deskew: assert property (@(posedge mclk) disable iff (!reset_n)
    s_deskew_armed |=> irq_req) else $error("deskew irq missing");

  a_irq_align: assert property (@(posedge mclk) disable iff (!reset_n)
    s_align_armed |=> irq_req) else $error("align irq missing");

  a_skip_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    s_skip_only |=> !irq_req) else $error("irq while alignment skipped");

  // ----------------------------------------
  // Register access checks
  // ----------------------------------------
  a_enable_low: assert property (@(posedge mclk) disable iff (!reset_n)
    st_reg.enable_reg[2:0] == 3'h0) else $error("unmapped enable bits set");

  a_enable_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    !(cfg_wr && cfg_addr == IRQ_ENABLE_A_ADDR) |=> $stable(st_reg.enable_reg))
    else $error("enable changed without write");

  a_enable_read: assert property (@(posedge mclk) disable iff (!reset_n)
    s_read_enable |=> cfg_rdata == $past(st_reg.enable_reg)) else $error("enable read wrong");

  // Read data must stand between reads, software may sample late
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_rd |=> $stable(cfg_rdata)) else $error("read data changed");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    s_read_unmapped |=> cfg_rdata == 8'h00) else $error("unmapped read not zero");

  a_lane6_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_rd && cfg_addr == LANE6_STATUS_ADDR) |=> cfg_rdata == $past(lane_status[0]))
    else $error("lane 6 read wrong");
endmodule

// [tb/lane_tx_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far-end transmitter: counts and sync levels
// ----------------------------------------
module lane_tx_model (
  input wire logic [7:0] err_level, // Lane 7 base error count
  input wire logic [3:0] sync_level, // Deskew, align, frame, code group
  input wire logic csum_bad, // Corrupt the sent checksum
  output logic [15:0] disp_cnt, // Disparity counts
  output logic [15:0] inv_cnt, // Not-in-table counts
  output logic [15:0] stray_cnt, // Unexpected K counts
  output logic [15:0] rx_csum, // Sent checksums
  output logic [15:0] calc_csum, // Computed checksums
  output logic [1:0] deskew, // Deskew per lane
  output logic [1:0] align, // Align sync per lane
  output logic [1:0] frame, // Frame sync per lane
  output logic [1:0] cgs // Code group sync per lane
);
  // Lane 6 kept quiet so lane mixing shows up in lane 7 reads
  assign disp_cnt = {err_level, 8'h00};
  assign inv_cnt = {err_level ^ 8'h01, 8'h00};
  assign stray_cnt = {err_level + 8'h01, 8'h00};
  assign rx_csum = {8'h5A ^ {7'h00, csum_bad}, 8'h5A};
  assign calc_csum = {8'h5A, 8'hA5};
  assign deskew = {sync_level[3], 1'b0};
  assign align = {sync_level[2], 1'b0};
  assign frame = {sync_level[1], 1'b0};
  assign cgs = {sync_level[0], 1'b0};
endmodule

// [tb/serial_lane_link_status_irq_enable_test.sv]
`timescale 1ns/1ps
module serial_lane_link_status_irq_enable_test;
  import lane_status_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, skip = 1'b0, csum_bad = 1'b1;
  logic [11:0] cfg_addr = 12'h000;
  logic [7:0] cfg_wdata = 8'h00, err_level = 8'h00, cfg_rdata, thr = 8'h10;
  logic [3:0] sync_level = 4'h0;
  logic [15:0] dc, ic, sc, rc, cc;
  logic [1:0] dk, al, fr, cg;
  logic irq_req;
  int err_count = 0, samples_checked = 0;
  lane_tx_model far (.err_level(err_level), .sync_level(sync_level), .csum_bad(csum_bad), .disp_cnt(dc),
    .inv_cnt(ic), .stray_cnt(sc), .rx_csum(rc), .calc_csum(cc), .deskew(dk), .align(al), .frame(fr), .cgs(cg));
  lane_link_status_bank DUT (.mclk(mclk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .error_threshold(thr),
    .skip_alignment_sequence(skip), .disparity_count(dc), .invalid_count(ic), .stray_count(sc),
    .deskew_ok(dk), .align_sync(al), .rx_checksum(rc), .calc_checksum(cc), .frame_sync(fr),
    .codegroup_sync(cg), .irq_req(irq_req));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  initial begin
    forever #5 mclk = ~mclk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge mclk);
    cfg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk(cfg_rdata, e);
  endtask
  // Status lags inputs, irq one more stage: three edges settle both
  task drive(input logic [7:0] e, input logic [3:0] s, input logic c, input logic k);
    @(posedge mclk);
    err_level <= e;
    sync_level <= s;
    csum_bad <= c;
    skip <= k;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task summarize;
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task reset_scen;
    rd(LANE7_STATUS_ADDR, 8'h00);
    rd(IRQ_ENABLE_A_ADDR, 8'h00);
  endtask
  task status_scen;
    drive(8'h10, 4'hF, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h00);
    rd(LANE7_STATUS_ADDR, 8'hFF);
    rd(LANE6_STATUS_ADDR, 8'h00);
    drive(8'h0F, 4'hA, 1'b1, 1'b0);
    rd(LANE7_STATUS_ADDR, 8'h32);
    drive(8'h10, 4'h5, 1'b0, 1'b0);
    rd(LANE7_STATUS_ADDR, 8'hED);
    wr(LANE7_STATUS_ADDR, 8'h00);
    rd(LANE7_STATUS_ADDR, 8'hED);
  endtask
  task enable_scen;
    wr(IRQ_ENABLE_A_ADDR, 8'hFF);
    rd(IRQ_ENABLE_A_ADDR, 8'hF8);
    rd(12'h123, 8'h00);
  endtask
  task irq_scen;
    wr(IRQ_ENABLE_A_ADDR, 8'h20);
    drive(8'h0F, 4'hF, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h01);
    wr(IRQ_ENABLE_A_ADDR, 8'h80);
    drive(8'h0F, 4'hF, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h00);
    wr(IRQ_ENABLE_A_ADDR, 8'h08);
    drive(8'h00, 4'h0, 1'b0, 1'b1);
    chk({7'h00, irq_req}, 8'h00);
    drive(8'h00, 4'h0, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h01);
  endtask
  // Threshold moved down to the count itself: equal must set the flag
  task thresh_scen;
    thr <= 8'h0F;
    drive(8'h0F, 4'hF, 1'b0, 1'b0);
    rd(LANE7_STATUS_ADDR, 8'hBF);
    thr <= 8'h10;
    drive(8'h0F, 4'hF, 1'b0, 1'b0);
    rd(LANE7_STATUS_ADDR, 8'h3F);
  endtask
  // Lane 6 deskew never achieved in the model, so the event stands
  task deskew_scen;
    wr(IRQ_ENABLE_A_ADDR, 8'h10);
    drive(8'h00, 4'hF, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h01);
    drive(8'h00, 4'hF, 1'b0, 1'b1);
    chk({7'h00, irq_req}, 8'h00);
  endtask
  task mid_reset_scen;
    wr(IRQ_ENABLE_A_ADDR, 8'hF8);
    rd(IRQ_ENABLE_A_ADDR, 8'hF8);
    drive(8'h10, 4'h0, 1'b0, 1'b0);
    chk({7'h00, irq_req}, 8'h01);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h00, irq_req}, 8'h00);
    chk(cfg_rdata, 8'h00);
    @(posedge mclk);
    reset_n <= 1'b1;
    rd(IRQ_ENABLE_A_ADDR, 8'h00);
    chk({7'h00, irq_req}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    reset_scen();
    status_scen();
    enable_scen();
    irq_scen();
    thresh_scen();
    deskew_scen();
    mid_reset_scen();
    summarize();
  end
endmodule
